// ### logic/brv_regs.sv
`timescale 1ns/10ps
`default_nettype none
module brv_regs (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // factory straps, caught once after reset release
  input wire logic otp_set_select_i,
  input wire logic sleep_pin_is_six_i,
  input wire logic rail2_fine_range_i,
  // configuration memory read port, data sampled on the edge that ends otp_rd_o
  output logic otp_rd_o,
  output logic [3:0] otp_addr_o,
  input wire logic [7:0] otp_data_i,
  // byte register port from the serial management front end
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic cfg_loaded_o,
  // active-low sleep control pins
  input wire logic control_pin_three_sleep_n,
  input wire logic control_pin_six_sleep_n,
  input wire logic rail4_seq_enable_i,
  input wire logic [6:0] rail4_normal_code,
  input wire logic [6:0] rail4_sleep_code,
  // regulator controls
  output logic [6:0] rail2_code_o,
  output logic rail2_step_fine_o,
  output logic rail2_passive_ramp_down,
  output logic rail2_down_step_o,
  output logic [6:0] rail3_code_o,
  output logic rail3_passive_ramp_down,
  output logic rail3_down_step_o,
  output logic rail3_in_sleep_o,
  output logic [6:0] rail4_code_o,
  output logic rail4_in_sleep_o,
  output logic rail4_forced_pwm_o,
  output logic rail4_run_o
);
  import brv_pkg::*;

  typedef struct packed {
    brv_load_e st;
    logic [2:0] idx;
    logic otp_set;
    logic pin_six;
    logic fine;
    logic [BRV_NUM_REGS-1:0][7:0] regs;
    logic [7:0] rdata;
    logic ack;
    logic otp_rd;
    logic [6:0] r2_code;
    logic [6:0] r3_code;
    logic [6:0] r4_code;
    logic r2_down;
    logic r3_down;
    logic r3_sleep;
    logic r4_sleep;
    logic r4_run;
  } brv_state_s;

  localparam logic [2:0] IDX_R2 = 3'h0;
  localparam logic [2:0] IDX_R3D = 3'h1;
  localparam logic [2:0] IDX_R3V = 3'h2;
  localparam logic [2:0] IDX_R3S = 3'h3;
  localparam logic [2:0] IDX_R4 = 3'h4;
  localparam logic [2:0] IDX_LAST = 3'(BRV_NUM_REGS - 1);

  logic rst_meta_reg;
  logic rst_n_reg;
  logic [1:0] pins_level;
  brv_state_s state_reg;
  brv_state_s state_next;

  // maps a bus offset onto a register slot; hit is low for unmapped offsets
  function automatic logic [3:0] decode(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - BRV_OFS_RAIL2_CONTROL;
    if (addr >= BRV_OFS_RAIL2_CONTROL && addr <= BRV_OFS_RAIL4_CONTROL) begin
      decode = {1'b1, rel[2:0]};
    end else begin
      decode = 4'h0;
    end
  endfunction

  // store one byte into a slot, clearing reserved bits and keeping the old rail four sleep field on bad values
  function automatic logic [7:0] store(input logic [2:0] idx, input logic [7:0] old, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    case (idx)
      IDX_R3V: v = d & BRV_MASK_RAIL3_VOLTAGE;
      IDX_R4: begin
        v = d & BRV_MASK_RAIL4_CONTROL;
        if (d[BRV_R4_SLP_MSB:BRV_R4_SLP_LSB] != BRV_R4_SLP_OFF &&
            d[BRV_R4_SLP_MSB:BRV_R4_SLP_LSB] != BRV_R4_SLP_ON) begin
          v[BRV_R4_SLP_MSB:BRV_R4_SLP_LSB] = old[BRV_R4_SLP_MSB:BRV_R4_SLP_LSB];
        end
      end
      default: v = d;
    endcase
    store = v;
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  brv_pin_sync #(
    .WIDTH(2),
    .IDLE(2'h3)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_reg),
    .pin_i({control_pin_six_sleep_n, control_pin_three_sleep_n}),
    .level_o(pins_level)
  );

  always_comb begin
    logic [3:0] hit;
    logic sleep_low;
    logic [7:0] r2;
    logic [7:0] r3v;
    logic [7:0] r3s;
    logic [7:0] r4;
    logic [6:0] r2_new;
    logic [6:0] r3_new;
    hit = decode(reg_addr_i);
    r2 = state_reg.regs[IDX_R2];
    r3v = state_reg.regs[IDX_R3V];
    r3s = state_reg.regs[IDX_R3S];
    r4 = state_reg.regs[IDX_R4];
    sleep_low = state_reg.pin_six ? ~pins_level[1] : ~pins_level[0];
    r2_new = 7'h00;
    r3_new = 7'h00;
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.otp_rd = 1'b0;
    state_next.r2_down = 1'b0;
    state_next.r3_down = 1'b0;

    case (state_reg.st)
      BRV_ST_STRAP: begin
        state_next.pin_six = sleep_pin_is_six_i;
        state_next.otp_set = otp_set_select_i;
        state_next.fine = rail2_fine_range_i;
        state_next.idx = IDX_R2;
        state_next.st = BRV_ST_REQ;
      end
      BRV_ST_REQ: begin
        state_next.otp_rd = 1'b1;
        state_next.st = BRV_ST_WAIT;
      end
      BRV_ST_WAIT: begin
        state_next.regs[state_reg.idx] = store(state_reg.idx, state_reg.regs[state_reg.idx], otp_data_i);
        if (state_reg.idx == IDX_LAST) begin
          state_next.st = BRV_ST_RUN;
        end else begin
          state_next.idx = state_reg.idx + 3'h1;
          state_next.st = BRV_ST_REQ;
        end
      end
      BRV_ST_RUN: begin
        if (reg_wr_i) begin
          state_next.ack = 1'b1;
          if (hit[3]) begin
            state_next.regs[hit[2:0]] = store(hit[2:0], state_reg.regs[hit[2:0]], reg_wdata_i);
          end
        end else if (reg_rd_i) begin
          state_next.ack = 1'b1;
          state_next.rdata = hit[3] ? state_reg.regs[hit[2:0]] : 8'h00;
        end
      end
      default: begin
        state_next.st = BRV_ST_STRAP;
      end
    endcase

    // regulation follows the stored bytes from the cycle after they change

    state_next.r3_sleep = r3s[BRV_SLEEP_EN_BIT] & sleep_low;
    state_next.r4_sleep = (r4[BRV_R4_SLP_MSB:BRV_R4_SLP_LSB] == BRV_R4_SLP_ON) & sleep_low;

    r2_new = r2[BRV_CODE_MSB:BRV_CODE_LSB];
    r3_new = state_next.r3_sleep ? r3s[BRV_CODE_MSB:BRV_CODE_LSB] : r3v[BRV_CODE_MSB:BRV_CODE_LSB];
    state_next.r4_code = state_next.r4_sleep ? rail4_sleep_code : rail4_normal_code;

    if (state_reg.st == BRV_ST_RUN) begin
      state_next.r2_code = r2_new;
      state_next.r3_code = r3_new;
      state_next.r2_down = r2_new < state_reg.r2_code;
      state_next.r3_down = r3_new < state_reg.r3_code;
      state_next.r4_run = r4[BRV_R4_ON_BIT] & rail4_seq_enable_i;
    end else begin
      state_next.r2_code = r2_new;
      state_next.r3_code = r3_new;
      state_next.r4_run = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= '{
        st: BRV_ST_STRAP,
        idx: IDX_R2,
        otp_set: 1'b0,
        pin_six: 1'b0,
        fine: 1'b0,
        regs: {BRV_RST_RAIL4_CONTROL, BRV_RST_RAIL3_SLEEP, BRV_RST_RAIL3_VOLTAGE,
               BRV_RST_RAIL3_DECAY, BRV_RST_RAIL2_CONTROL},
        rdata: 8'h00,
        ack: 1'b0,
        otp_rd: 1'b0,
        r2_code: 7'h00,
        r3_code: 7'h00,
        r4_code: 7'h00,
        r2_down: 1'b0,
        r3_down: 1'b0,
        r3_sleep: 1'b0,
        r4_sleep: 1'b0,
        r4_run: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign otp_rd_o = state_reg.otp_rd;
  assign otp_addr_o = {state_reg.otp_set, state_reg.idx};
  assign reg_rdata_o = state_reg.rdata;
  assign reg_ack_o = state_reg.ack;
  assign cfg_loaded_o = (state_reg.st == BRV_ST_RUN);

  assign rail2_code_o = state_reg.r2_code;
  assign rail2_step_fine_o = state_reg.fine;
  assign rail2_passive_ramp_down = state_reg.regs[IDX_R2][BRV_DECAY_BIT];
  assign rail2_down_step_o = state_reg.r2_down;
  // rail three has no range choice, always the 25 mV steps
  assign rail3_code_o = state_reg.r3_code;
  assign rail3_passive_ramp_down = state_reg.regs[IDX_R3D][BRV_DECAY_BIT];
  assign rail3_down_step_o = state_reg.r3_down;
  assign rail3_in_sleep_o = state_reg.r3_sleep;
  assign rail4_code_o = state_reg.r4_code;
  assign rail4_in_sleep_o = state_reg.r4_sleep;
  // mode bit relied on being 1
  assign rail4_forced_pwm_o = state_reg.regs[IDX_R4][BRV_R4_MODE_BIT];
  assign rail4_run_o = state_reg.r4_run;

endmodule // brv_regs
`default_nettype wire

// ### logic/brv_pkg.sv
package brv_pkg;

  localparam logic [7:0] BRV_OFS_RAIL2_CONTROL = 8'h21;
  localparam logic [7:0] BRV_OFS_RAIL3_DECAY = 8'h22;
  localparam logic [7:0] BRV_OFS_RAIL3_VOLTAGE = 8'h23;
  localparam logic [7:0] BRV_OFS_RAIL3_SLEEP = 8'h24;
  localparam logic [7:0] BRV_OFS_RAIL4_CONTROL = 8'h25;
  localparam int unsigned BRV_NUM_REGS = 5;

  // code fields sit in bits 7:1 of every voltage-carrying register
  localparam int unsigned BRV_CODE_MSB = 7;
  localparam int unsigned BRV_CODE_LSB = 1;
  localparam int unsigned BRV_DECAY_BIT = 0;
  localparam int unsigned BRV_SLEEP_EN_BIT = 0;
  localparam int unsigned BRV_R4_SLP_MSB = 5;
  localparam int unsigned BRV_R4_SLP_LSB = 4;
  localparam int unsigned BRV_R4_MODE_BIT = 1;
  localparam int unsigned BRV_R4_ON_BIT = 0;

  localparam logic [7:0] BRV_RST_RAIL2_CONTROL = 8'h00;
  localparam logic [7:0] BRV_RST_RAIL3_DECAY = 8'h00;
  localparam logic [7:0] BRV_RST_RAIL3_VOLTAGE = 8'h00;
  localparam logic [7:0] BRV_RST_RAIL3_SLEEP = 8'h00;
  localparam logic [7:0] BRV_RST_RAIL4_CONTROL = 8'h0c;

  // writable masks; cleared bits read as zero
  localparam logic [7:0] BRV_MASK_RAIL3_VOLTAGE = 8'hfe;
  localparam logic [7:0] BRV_MASK_RAIL4_CONTROL = 8'h3f;
  localparam logic [1:0] BRV_R4_SLP_OFF = 2'h0;
  localparam logic [1:0] BRV_R4_SLP_ON = 2'h3;

  typedef enum logic [3:0] {
    BRV_ST_STRAP = 4'h1,
    BRV_ST_REQ = 4'h2,
    BRV_ST_WAIT = 4'h4,
    BRV_ST_RUN = 4'h8
  } brv_load_e;

endpackage

// ### logic/brv_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module brv_pin_sync #(
  parameter int unsigned WIDTH = 2,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } brv_sync_s;

  brv_sync_s state_reg;
  brv_sync_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.meta = pin_i;
    state_next.s2 = state_reg.meta;
    state_next.s3 = state_reg.s2;
    // a bit only moves once two settled stages agree, so one glitchy sample is dropped
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.level[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '{meta: IDLE, s2: IDLE, s3: IDLE, level: IDLE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_o = state_reg.level;

endmodule // brv_pin_sync
`default_nettype wire

// ### tb/brv_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module brv_regs_props (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic cfg_loaded_o,
  input wire logic otp_rd_o,
  input wire logic control_pin_three_sleep_n,
  input wire logic control_pin_six_sleep_n,
  input wire logic rail4_seq_enable_i,
  input wire logic rail3_in_sleep_o,
  input wire logic rail4_in_sleep_o,
  input wire logic rail4_forced_pwm_o,
  input wire logic rail4_run_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic req;
  logic wr4;
  assign req = reg_wr_i || reg_rd_i;
  assign wr4 = reg_wr_i && cfg_loaded_o && reg_addr_i == 8'h25;
  a_ack_taken: assert property (req && cfg_loaded_o |=> reg_ack_o)
    else $error("request not acknowledged");
  a_no_early_ack: assert property (!cfg_loaded_o |=> !reg_ack_o)
    else $error("ack before configuration loaded");
  a_ack_cause: assert property (reg_ack_o |-> $past(req))
    else $error("ack without request");
  a_rail3_bit0: assert property (reg_ack_o && $past(reg_rd_i && !reg_wr_i && reg_addr_i == 8'h23)
    |-> !reg_rdata_o[0])
    else $error("reserved bit of rail three code reads one");
  a_rail4_top: assert property (reg_ack_o && $past(reg_rd_i && !reg_wr_i && reg_addr_i == 8'h25)
    |-> reg_rdata_o[7:6] == 2'h0)
    else $error("rail four top bits read nonzero");
  a_rail4_gate: assert property (rail4_run_o |-> $past(rail4_seq_enable_i))
    else $error("rail four runs without sequencer");
  a_rail4_off: assert property (wr4 && !reg_wdata_i[0] |-> ##2 !rail4_run_o)
    else $error("rail four not forced off");
  a_rail4_mode: assert property (wr4 |-> ##2 rail4_forced_pwm_o == $past(reg_wdata_i[1], 2))
    else $error("rail four mode bit not applied");
  a_pins_idle: assert property ((control_pin_three_sleep_n && control_pin_six_sleep_n) [*7]
    |-> !rail3_in_sleep_o && !rail4_in_sleep_o)
    else $error("sleep with pins idle");
  a_otp_gap: assert property (otp_rd_o |=> !otp_rd_o)
    else $error("configuration reads back to back");
  c_write: cover property (wr4 ##2 !rail4_run_o);
  c_sleep3: cover property (rail3_in_sleep_o);
  c_sleep4: cover property (rail4_in_sleep_o);
endmodule // brv_regs_props
bind brv_regs brv_regs_props brv_regs_props_inst (.*);
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import brv_pkg::*;
  logic core_clk_i, nrst_i, reg_wr_i, reg_rd_i, otp_rd_o, reg_ack_o, cfg_loaded_o, seen;
  logic otp_set_select_i, sleep_pin_is_six_i, rail2_fine_range_i, rail4_seq_enable_i;
  logic control_pin_three_sleep_n, control_pin_six_sleep_n;
  logic [3:0] otp_addr_o;
  logic [7:0] otp_data_i, reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
  logic [6:0] rail4_normal_code, rail4_sleep_code, rail2_code_o, rail3_code_o, rail4_code_o;
  logic rail2_step_fine_o, rail2_passive_ramp_down, rail2_down_step_o, rail3_passive_ramp_down;
  logic rail3_down_step_o, rail3_in_sleep_o, rail4_in_sleep_o, rail4_forced_pwm_o, rail4_run_o;
  int n_fail, cmp_count, cyc, i;
  logic [7:0] otp [16];
  logic [7:0] rows [7][3];
  logic [7:0] pv [5];
  brv_regs brv_regs_inst (.*);
  initial begin
    core_clk_i = 0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // memory answers inside the read pulse, ready for the edge that ends it; otherwise it toggles
  always @(negedge core_clk_i) begin
    otp_data_i <= otp_rd_o ? otp[otp_addr_o] : ~otp_data_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 0;
    reg_rd_i <= 0;
    #1;
    rd = reg_rdata_o;
    chk("ack", 8'h01, {7'h0, reg_ack_o});
  endtask
  task automatic settle();
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask
  initial begin
    {cyc, n_fail, cmp_count, nrst_i, reg_wr_i, reg_rd_i, sleep_pin_is_six_i} = 0;
    {otp_set_select_i, rail2_fine_range_i, rail4_seq_enable_i} = 3'h7;
    {control_pin_three_sleep_n, control_pin_six_sleep_n} = 2'h3;
    {reg_addr_i, reg_wdata_i, otp_data_i} = 0;
    rail4_normal_code = 7'h11;
    rail4_sleep_code = 7'h22;
    otp = '{default: 8'hff};
    otp[8] = 8'h55;
    otp[9] = 8'h46;
    otp[10] = 8'h47;
    otp[11] = 8'h31;
    otp[12] = 8'hfd;
    pv = '{8'h55, 8'h46, 8'h46, 8'h31, 8'h3d};
    rows = '{'{8'h21, 8'ha4, 8'ha4}, '{8'h22, 8'hff, 8'hff}, '{8'h23, 8'hff, 8'hfe},
      '{8'h24, 8'h81, 8'h81}, '{8'h25, 8'hff, 8'h3f}, '{8'h25, 8'h1f, 8'h3f}, '{8'h30, 8'h5a, 8'h00}};
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1;
    @(posedge core_clk_i);
    reg_rd_i <= 1;
    @(posedge core_clk_i);
    reg_rd_i <= 0;
    #1;
    chk("early ack", 8'h00, {7'h0, reg_ack_o});
    for (i = 0; i < 50 && cfg_loaded_o !== 1'b1; i++) @(posedge core_clk_i);
    for (i = 0; i < 5; i++) begin
      acc(0, 8'h21 + 8'(i), 8'h00);
      chk("loaded", pv[i], rd);
    end
    chk("r2 code", 8'h2a, {1'b0, rail2_code_o});
    chk("r2 fine", 8'h01, {7'h0, rail2_step_fine_o});
    chk("r2 decay", 8'h01, {7'h0, rail2_passive_ramp_down});
    chk("r3 code", 8'h23, {1'b0, rail3_code_o});
    for (i = 0; i < 7; i++) begin
      acc(1, rows[i][0], rows[i][1]);
      acc(0, rows[i][0], 8'h00);
      chk("rdata", rows[i][2], rd);
    end
    settle();
    chk("r2 code", 8'h52, {1'b0, rail2_code_o});
    chk("r3 decay", 8'h01, {7'h0, rail3_passive_ramp_down});
    chk("r4 mode", 8'h01, {7'h0, rail4_forced_pwm_o});
    control_pin_three_sleep_n <= 0;
    settle();
    chk("r3 sleep", 8'h40, {1'b0, rail3_code_o});
    chk("r4 sleep", {1'b0, rail4_sleep_code}, {1'b0, rail4_code_o});
    control_pin_three_sleep_n <= 1;
    control_pin_six_sleep_n <= 0;
    settle();
    chk("other pin", 8'h7f, {1'b0, rail3_code_o});
    chk("r4 normal", {1'b0, rail4_normal_code}, {1'b0, rail4_code_o});
    control_pin_six_sleep_n <= 1;
    control_pin_three_sleep_n <= 0;
    acc(1, 8'h24, 8'h80);
    settle();
    chk("sleep off", 8'h7f, {1'b0, rail3_code_o});
    control_pin_three_sleep_n <= 1;
    acc(1, 8'h25, 8'h3e);
    settle();
    chk("r4 off", 8'h00, {7'h0, rail4_run_o});
    acc(1, 8'h25, 8'h3f);
    rail4_seq_enable_i <= 0;
    settle();
    chk("r4 seq", 8'h00, {7'h0, rail4_run_o});
    rail4_seq_enable_i <= 1;
    settle();
    chk("r4 on", 8'h01, {7'h0, rail4_run_o});
    seen = 0;
    acc(1, 8'h21, 8'h20);
    repeat (5) @(posedge core_clk_i) seen |= rail2_down_step_o;
    chk("down step", 8'h01, {7'h0, seen});
    seen = 0;
    acc(1, 8'h23, 8'h10);
    repeat (5) @(posedge core_clk_i) seen |= rail3_down_step_o;
    chk("r3 down step", 8'h01, {7'h0, seen});
    chk("r3 low code", 8'h08, {1'b0, rail3_code_o});
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
